// file: design/acnv_nv_seq.sv
`timescale 1ns/100ps
`default_nettype none
module acnv_nv_seq
   import acnv_pkg::*;
#(
   parameter int STROBE_CYC = ACNV_STROBE_CYC
)
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // command from the register
   input  wire logic        cmd,
   input  wire acnv_op_t    cmd_op,
   input  wire logic [7:0]  cmd_byte,
   output logic             busy,
   output logic [7:0]       rd_byte,
   output logic             rd_done,
   // external memory pins
   output logic [15:0]      nv_addr,
   output logic [7:0]       nv_dout,
   output logic             nv_dout_en,
   input  wire logic [7:0]  nv_din,
   output logic             nv_wr_n,
   output logic             nv_rd_n
);
   typedef enum logic [1:0]
   {
      S_IDLE   = 2'b00,
      S_LOAD   = 2'b01,
      S_STROBE = 2'b10,
      S_DONE   = 2'b11
   } acnv_seq_t;

   acnv_seq_t   st_r, st_nxt;
   acnv_op_t    op_r, op_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0]  wbyte_r, wbyte_nxt;
   logic [7:0]  rbyte_r, rbyte_nxt;
   logic        rdone_r, rdone_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [3:0]  wlen_r, wlen_nxt;

   // next state; commands while busy are dropped, software must wait
   always_comb
   begin
      st_nxt    = st_r;
      op_nxt    = op_r;
      addr_nxt  = addr_r;
      wbyte_nxt = wbyte_r;
      rbyte_nxt = rbyte_r;
      rdone_nxt = 1'b0;
      cnt_nxt   = cnt_r;
      case (st_r)
         S_IDLE:
            if (cmd)
            begin
               op_nxt    = cmd_op;
               wbyte_nxt = cmd_byte;
               cnt_nxt   = 4'(STROBE_CYC - 1);
               st_nxt    = (cmd_op[1]) ? S_STROBE : S_LOAD;
            end
         S_LOAD:
         begin
            // address loads only latch, no external cycle
            if (op_r == ACNV_OP_LD_LO)
               addr_nxt[7:0] = wbyte_r;
            else
               addr_nxt[15:8] = wbyte_r;
            st_nxt = S_IDLE;
         end
         S_STROBE:
            if (cnt_r == 4'h0)
            begin
               // sample read data at the end of the strobe
               if (op_r == ACNV_OP_READ)
               begin
                  rbyte_nxt = nv_din;
                  rdone_nxt = 1'b1;
               end
               st_nxt = S_DONE;
            end
            else
               cnt_nxt = cnt_r - 4'h1;
         S_DONE:
            st_nxt = S_IDLE;   // one cycle of address/data hold
         default:
            st_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_r    <= S_IDLE;
         op_r    <= ACNV_OP_LD_LO;
         addr_r  <= 16'h0000;
         wbyte_r <= 8'h00;
         rbyte_r <= 8'h00;
         rdone_r <= 1'b0;
         cnt_r   <= 4'h0;
      end
      else
      begin
         st_r    <= st_nxt;
         op_r    <= op_nxt;
         addr_r  <= addr_nxt;
         wbyte_r <= wbyte_nxt;
         rbyte_r <= rbyte_nxt;
         rdone_r <= rdone_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // outputs; busy spans the whole byte cycle
   assign busy       = (st_r != S_IDLE);
   assign rd_byte    = rbyte_r;
   assign rd_done    = rdone_r;
   assign nv_addr    = addr_r;
   assign nv_dout    = wbyte_r;
   assign nv_dout_en = (st_r == S_STROBE || st_r == S_DONE) &&
                       (op_r == ACNV_OP_WRITE);
   assign nv_wr_n    = !(st_r == S_STROBE && op_r == ACNV_OP_WRITE);
   assign nv_rd_n    = !(st_r == S_STROBE && op_r == ACNV_OP_READ);

   a_load_short: assert property (@(posedge mclk) disable iff (srst)
      (st_r == S_IDLE && cmd && !cmd_op[1]) |=> busy ##1 !busy)
      else $error("address load busy not one cycle");
   // low time of the write strobe, counted so the width check below
   // follows STROBE_CYC instead of a fixed repetition count
   always_comb
   begin
      wlen_nxt = nv_wr_n ? 4'h0 : wlen_r + 4'h1;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         wlen_r <= 4'h0;
      else
         wlen_r <= wlen_nxt;
   end

   a_strobe_width: assert property (@(posedge mclk) disable iff (srst)
      $rose(nv_wr_n) |-> wlen_r == 4'(STROBE_CYC))
      else $error("write strobe width wrong");
   a_busy_strobe: assert property (@(posedge mclk) disable iff (srst)
      (!nv_wr_n || !nv_rd_n) |-> busy ##1 busy)
      else $error("busy dropped during strobe");
endmodule : acnv_nv_seq
`default_nettype wire

// file: design/acnv_pkg.sv
package acnv_pkg;
   // register byte offsets on the add-on register port
   localparam logic [7:0]  ACNV_OFS_GENCTL   = 8'h3C;
   localparam logic [7:0]  ACNV_OFS_INTCSR   = 8'h38;
   // general control/status field positions
   localparam int          ACNV_B_GO         = 31;
   localparam int          ACNV_B_OPHI       = 30;
   localparam int          ACNV_B_OPLO       = 29;
   localparam int          ACNV_B_XCNT       = 28;
   localparam int          ACNV_B_MBRST      = 27;
   localparam int          ACNV_B_A2PRST     = 26;
   localparam int          ACNV_B_P2ARST     = 25;
   localparam int          ACNV_B_NVLSB      = 16;
   localparam int          ACNV_B_BISTLSB    = 12;
   localparam int          ACNV_B_MODELSB    = 6;
   // interrupt control/status field positions
   localparam int          ACNV_B_INSEL_LSB  = 0;
   localparam int          ACNV_B_INEN       = 4;
   localparam int          ACNV_B_INFLAG     = 16;
   localparam int          ACNV_B_IRQANY     = 23;
   // power-up values of the general register per bus-master mode
   localparam logic [31:0] ACNV_RST_PCI_MST  = 32'h000000F4;
   localparam logic [31:0] ACNV_RST_ADD_MST  = 32'h00000034;
   // non-volatile memory access commands
   typedef enum logic [1:0]
   {
      ACNV_OP_LD_LO = 2'b00,
      ACNV_OP_LD_HI = 2'b01,
      ACNV_OP_WRITE = 2'b10,
      ACNV_OP_READ  = 2'b11
   } acnv_op_t;
   // strobe width for one external byte cycle
   localparam int          ACNV_MCLK_PS      = 20000;
   localparam int          ACNV_STROBE_NS    = 100;
   localparam int          ACNV_STROBE_CYC   =
      (ACNV_STROBE_NS * 1000 + ACNV_MCLK_PS - 1) / ACNV_MCLK_PS;
endpackage : acnv_pkg

// file: design/acnv_regs.sv
`timescale 1ns/100ps
`default_nettype none
module acnv_regs
   import acnv_pkg::*;
#(
   parameter int STROBE_CYC = ACNV_STROBE_CYC
)
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // add-on register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [3:0]  reg_be,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   // bus-mastering mode strap, high for PCI-initiated
   input  wire logic        pci_init_master,
   // fifo status from the datapath
   input  wire logic        a2p_full,
   input  wire logic        a2p_four_empty,
   input  wire logic        a2p_empty,
   input  wire logic        p2a_full,
   input  wire logic        p2a_four_loaded,
   input  wire logic        p2a_empty,
   // incoming mailbox byte-written events, index mailbox*4+byte
   input  wire logic [15:0] inmb_byte_wr,
   output logic             inmb_irq,
   // one-shot resets and static controls
   output logic             mbox_flag_rst,
   output logic             a2p_flag_rst,
   output logic             p2a_flag_rst,
   output logic             xfer_cnt_en,
   output logic [3:0]       bist_code,
   // external non-volatile memory
   output logic [15:0]      nv_addr,
   output logic [7:0]       nv_dout,
   output logic             nv_dout_en,
   input  wire logic [7:0]  nv_din,
   output logic             nv_wr_n,
   output logic             nv_rd_n
);
   // register hit decode, shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction : hit

   logic        wr_ag, wr_ic;
   logic [31:0] rd_nxt, rd_r;
   logic [7:0]  nvf_r, nvf_nxt;
   acnv_op_t    lop_r, lop_nxt;
   logic        xcnt_r, xcnt_nxt;
   logic [3:0]  bist_r, bist_nxt;
   logic [2:0]  pls_r, pls_nxt;
   logic [1:0]  mode_r, mode_nxt;
   logic [4:0]  inctl_r, inctl_nxt;
   logic        infl_r, infl_nxt;
   logic        nv_cmd, nv_busy, nv_rdone, in_evt;
   logic [7:0]  nv_rbyte;

   assign wr_ag = reg_wr && hit(reg_addr, ACNV_OFS_GENCTL);
   assign wr_ic = reg_wr && hit(reg_addr, ACNV_OFS_INTCSR);

   // access starts only when idle; the top bit low means inactive
   assign nv_cmd = wr_ag && reg_be[3] && reg_wdata[ACNV_B_GO] &&
                   !nv_busy;

   // selected mailbox byte written by the PCI side, when enabled
   assign in_evt = inctl_r[ACNV_B_INEN] &&
                   inmb_byte_wr[inctl_r[3:0]];

   // general register next values
   always_comb
   begin
      nvf_nxt  = nvf_r;
      lop_nxt  = lop_r;
      xcnt_nxt = xcnt_r;
      bist_nxt = bist_r;
      pls_nxt  = 3'b000;   // reset pulses last exactly one cycle
      mode_nxt = {2{pci_init_master}};   // strap tracked, in reset too
      if (wr_ag && reg_be[3])
      begin
         xcnt_nxt = reg_wdata[ACNV_B_XCNT];
         pls_nxt  = reg_wdata[ACNV_B_MBRST:ACNV_B_P2ARST];
      end
      if (nv_cmd)
         lop_nxt = acnv_op_t'(reg_wdata[ACNV_B_OPHI:ACNV_B_OPLO]);
      // the field takes a byte only with a command, so it is not
      // overwritten by an unrelated write while a read is pending
      if (nv_cmd && reg_be[2])
         nvf_nxt = reg_wdata[ACNV_B_NVLSB +: 8];
      if (nv_rdone)
         nvf_nxt = nv_rbyte;
      if (wr_ag && reg_be[1])
         bist_nxt = reg_wdata[ACNV_B_BISTLSB +: 4];
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         nvf_r  <= 8'h00;
         lop_r  <= ACNV_OP_LD_LO;
         xcnt_r <= 1'b0;
         bist_r <= 4'h0;
         pls_r  <= 3'b000;
         mode_r <= mode_nxt;   // add-on mode must read 34h at once
      end
      else
      begin
         nvf_r  <= nvf_nxt;
         lop_r  <= lop_nxt;
         xcnt_r <= xcnt_nxt;
         bist_r <= bist_nxt;
         pls_r  <= pls_nxt;
         mode_r <= mode_nxt;
      end
   end

   // interrupt control next values; a new event beats the clear
   always_comb
   begin
      inctl_nxt = inctl_r;
      infl_nxt  = infl_r;
      if (wr_ic && reg_be[0])
         inctl_nxt = reg_wdata[ACNV_B_INEN:ACNV_B_INSEL_LSB];
      if (wr_ic && reg_be[2] && reg_wdata[ACNV_B_INFLAG])
         infl_nxt = 1'b0;
      if (in_evt)
         infl_nxt = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         inctl_r <= 5'h00;
         infl_r  <= 1'b0;
      end
      else
      begin
         inctl_r <= inctl_nxt;
         infl_r  <= infl_nxt;
      end
   end

   // read mux; write-only bits and reserved bits read zero
   always_comb
   begin
      rd_nxt = 32'h00000000;
      if (reg_rd && hit(reg_addr, ACNV_OFS_GENCTL))
      begin
         rd_nxt[ACNV_B_GO]                    = nv_busy;
         rd_nxt[ACNV_B_OPHI:ACNV_B_OPLO]      = lop_r;
         rd_nxt[ACNV_B_XCNT]                  = xcnt_r;
         rd_nxt[ACNV_B_NVLSB +: 8]            = nvf_r;
         rd_nxt[ACNV_B_BISTLSB +: 4]          = bist_r;
         rd_nxt[ACNV_B_MODELSB +: 2]          = mode_r;
         rd_nxt[5:0] = {a2p_empty, a2p_four_empty, a2p_full,
                        p2a_empty, p2a_four_loaded, p2a_full};
      end
      else if (reg_rd && hit(reg_addr, ACNV_OFS_INTCSR))
      begin
         rd_nxt[ACNV_B_INEN:ACNV_B_INSEL_LSB] = inctl_r;
         rd_nxt[ACNV_B_INFLAG]                = infl_r;
         rd_nxt[ACNV_B_IRQANY]                = infl_r;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         rd_r <= 32'h00000000;
      else
         rd_r <= rd_nxt;
   end

   acnv_nv_seq #(
      .STROBE_CYC (STROBE_CYC)
   ) u_seq (
      .mclk       (mclk),
      .srst       (srst),
      .cmd        (nv_cmd),
      .cmd_op     (acnv_op_t'(reg_wdata[ACNV_B_OPHI:ACNV_B_OPLO])),
      .cmd_byte   (reg_wdata[ACNV_B_NVLSB +: 8]),
      .busy       (nv_busy),
      .rd_byte    (nv_rbyte),
      .rd_done    (nv_rdone),
      .nv_addr    (nv_addr),
      .nv_dout    (nv_dout),
      .nv_dout_en (nv_dout_en),
      .nv_din     (nv_din),
      .nv_wr_n    (nv_wr_n),
      .nv_rd_n    (nv_rd_n)
   );

   // outputs
   assign reg_rdata     = rd_r;
   assign inmb_irq      = infl_r;
   assign mbox_flag_rst = pls_r[2];
   assign a2p_flag_rst  = pls_r[1];
   assign p2a_flag_rst  = pls_r[0];
   assign xfer_cnt_en   = xcnt_r;
   assign bist_code     = bist_r;

   a_pulse_mbox: assert property (@(posedge mclk) disable iff (srst)
      (wr_ag && reg_be[3] && reg_wdata[ACNV_B_MBRST]) |=> mbox_flag_rst
      ##1 (!mbox_flag_rst || $past(wr_ag)))
      else $error("mailbox reset pulse wrong");
   a_pulse_fifo: assert property (@(posedge mclk) disable iff (srst)
      (a2p_flag_rst || p2a_flag_rst) |->
      $past(wr_ag) && $past(reg_be[3]))
      else $error("fifo reset pulse without write");
   a_wo_zero: assert property (@(posedge mclk) disable iff (srst)
      $past(reg_rd) |-> reg_rdata[27:24] == 4'h0)
      else $error("write-only bits read nonzero");
   a_go_reads: assert property (@(posedge mclk) disable iff (srst)
      (nv_cmd && reg_wdata[ACNV_B_OPHI]) ##2
      (reg_rd && hit(reg_addr, ACNV_OFS_GENCTL)) |=>
      reg_rdata[ACNV_B_GO])
      else $error("go bit not busy after start");
   a_irq_set: assert property (@(posedge mclk) disable iff (srst)
      in_evt |=> inmb_irq)
      else $error("incoming event lost");
   a_rd_field: assert property (@(posedge mclk) disable iff (srst)
      nv_rdone |=> nvf_r == $past(nv_rbyte))
      else $error("read byte not placed in field");
   a_bist_map: assert property (@(posedge mclk) disable iff (srst)
      (wr_ag && reg_be[1]) |=> bist_code == $past(reg_wdata[15:12]))
      else $error("condition code not forwarded");
endmodule : acnv_regs
`default_nettype wire

// file: testbench/acnv_nv_mem.sv
`timescale 1ns/100ps
`default_nettype none
module acnv_nv_mem
(
   // clock
   input  wire logic        mclk,
   // memory pins
   input  wire logic [15:0] nv_addr,
   input  wire logic [7:0]  nv_dout,
   input  wire logic        nv_wr_n,
   input  wire logic        nv_rd_n,
   output logic [7:0]       nv_din,
   // low time of the last write strobe, in cycles
   output int               wr_len
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   int         cnt  = 0;
   initial wr_len = 0;
   // store on every low strobe cycle and time the strobe
   always @(posedge mclk)
   begin
      if (!nv_wr_n)
      begin
         mem[nv_addr] <= nv_dout;
         cnt          <= cnt + 1;
      end
      else if (cnt != 0)
      begin
         wr_len <= cnt;
         cnt    <= 0;
      end
      if (!nv_rd_n)
         last <= mem[nv_addr];
   end
   // released lines show the inverse so a stale capture cannot match
   assign nv_din = nv_rd_n ? ~last : mem[nv_addr];
endmodule : acnv_nv_mem
`default_nettype wire

// file: testbench/addon_control_nv_access_bench.sv
`timescale 1ns/100ps
`default_nettype none
module addon_control_nv_access_bench;
   import acnv_pkg::*;
   localparam int STB = 3;
   logic        mclk, srst, reg_wr, reg_rd, pci_init_master, inmb_irq;
   logic        mbox_flag_rst, a2p_flag_rst, p2a_flag_rst, nv_wr_n, nv_rd_n;
   logic        xfer_cnt_en, nv_dout_en;
   logic [7:0]  reg_addr, nv_dout, nv_din;
   logic [3:0]  reg_be, bist_code;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [5:0]  flags;
   logic [15:0] inmb_byte_wr, nv_addr;
   int          fails = 0;
   int          n_checks = 0;
   int          wr_len;

   acnv_regs #(.STROBE_CYC(STB)) u_acnv_regs
   (
      .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .pci_init_master(pci_init_master),
      .a2p_full(flags[3]), .a2p_four_empty(flags[4]),
      .a2p_empty(flags[5]), .p2a_full(flags[0]),
      .p2a_four_loaded(flags[1]), .p2a_empty(flags[2]),
      .inmb_byte_wr(inmb_byte_wr), .inmb_irq(inmb_irq),
      .mbox_flag_rst(mbox_flag_rst), .a2p_flag_rst(a2p_flag_rst),
      .p2a_flag_rst(p2a_flag_rst), .xfer_cnt_en(xfer_cnt_en),
      .bist_code(bist_code),
      .nv_addr(nv_addr), .nv_dout(nv_dout), .nv_dout_en(nv_dout_en),
      .nv_din(nv_din), .nv_wr_n(nv_wr_n), .nv_rd_n(nv_rd_n)
   );

   acnv_nv_mem u_acnv_nv_mem
   (
      .mclk(mclk), .nv_addr(nv_addr), .nv_dout(nv_dout),
      .nv_wr_n(nv_wr_n), .nv_rd_n(nv_rd_n), .nv_din(nv_din),
      .wr_len(wr_len)
   );

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      @(posedge mclk) #1;
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_be    = be;
      reg_wdata = d;
      @(posedge mclk) #1;
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge mclk) #1;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(posedge mclk) #1;
      reg_rd = 1'b0;
      rv     = reg_rdata;
   endtask : rd

   // one access command, go bit set
   task automatic go(input acnv_op_t op, input logic [7:0] b);
      wr(ACNV_OFS_GENCTL, 4'hC, {1'b1, op, 5'h00, b, 16'h0000});
   endtask : go

   // wait for the ready bit under a bound of n reads
   task automatic poll(input int n);
      int i;
      i = 0;
      do
      begin
         rd(ACNV_OFS_GENCTL);
         i++;
      end
      while (rv[31] && i < n);
      chk("nv ready", rv[31], 0);
   endtask : poll

   task automatic pulse(input int k);
      @(posedge mclk) #1;
      inmb_byte_wr = 16'h0001 << k;
      @(posedge mclk) #1;
      inmb_byte_wr = 16'h0000;
      @(posedge mclk) #1;
   endtask : pulse

   task automatic summarize();
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // free-running 50 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // run is a few hundred cycles, so this only trips on a hang
   initial
   begin
      #200000;
      fails++;
      summarize();
   end

   initial
   begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_be = 4'h0;
      reg_wdata = 32'h0;
      pci_init_master = 1'b1;
      flags = 6'h34;
      inmb_byte_wr = 16'h0000;
      repeat (3) @(posedge mclk);
      #1 srst = 1'b0;
      rd(ACNV_OFS_GENCTL);
      chk("power-up pci", rv, 32'h000000F4);
      pci_init_master = 1'b0;
      rd(ACNV_OFS_GENCTL);
      chk("power-up addon", rv, 32'h00000034);
      for (int i = 0; i < 6; i++)
      begin
         flags = 6'h01 << i;
         rd(ACNV_OFS_GENCTL);
         chk("fifo flag", rv & 32'h3F, 32'h1 << i);
      end
      // each reset bit gives a single pulse on its own output
      for (int i = 0; i < 3; i++)
      begin
         wr(ACNV_OFS_GENCTL, 4'h8, 32'h02000000 << i);
         chk("rst pulse", {mbox_flag_rst, a2p_flag_rst, p2a_flag_rst},
             3'b001 << i);
         @(posedge mclk) #1;
         chk("rst end", {mbox_flag_rst, a2p_flag_rst, p2a_flag_rst}, 0);
      end
      rd(ACNV_OFS_GENCTL);
      chk("rst read", rv[27:25], 0);
      wr(ACNV_OFS_GENCTL, 4'h2, 32'h0000A000);
      chk("bist out", bist_code, 4'hA);
      rd(ACNV_OFS_GENCTL);
      chk("bist read", rv[15:12], 4'hA);
      wr(ACNV_OFS_GENCTL, 4'h8, 32'h10000000);
      chk("xfer en", xfer_cnt_en, 1);
      // memory write, then a load issued while busy must be dropped
      go(ACNV_OP_LD_LO, 8'h34);
      poll(4);
      go(ACNV_OP_LD_HI, 8'h12);
      poll(4);
      chk("nv addr", nv_addr, 16'h1234);
      wr(ACNV_OFS_GENCTL, 4'hC, 32'h00770000);
      chk("inactive", nv_addr, 16'h1234);
      go(ACNV_OP_WRITE, 8'hA5);
      go(ACNV_OP_LD_LO, 8'hFF);
      rd(ACNV_OFS_GENCTL);
      chk("busy", rv[31], 1);
      poll(30);
      chk("addr held", nv_addr, 16'h1234);
      chk("mem byte", u_acnv_nv_mem.mem[16'h1234], 8'hA5);
      chk("strobe len", wr_len, STB);
      go(ACNV_OP_LD_LO, 8'h35);
      poll(4);
      go(ACNV_OP_WRITE, 8'h5A);
      chk("dout en", nv_dout_en, 1);
      poll(30);
      chk("dout off", nv_dout_en, 0);
      go(ACNV_OP_LD_LO, 8'h34);
      poll(4);
      go(ACNV_OP_READ, 8'h00);
      poll(30);
      chk("nv read", rv[23:16], 8'hA5);
      // every mailbox/byte code, with a neighbour event as decoy
      for (int k = 0; k < 16; k++)
      begin
         wr(ACNV_OFS_INTCSR, 4'h1, 32'h10 | k);
         pulse((k + 1) % 16);
         chk("irq other", inmb_irq, 0);
         pulse(k);
         chk("irq sel", inmb_irq, 1);
         wr(ACNV_OFS_INTCSR, 4'h4, 32'h00010000);
         @(posedge mclk) #1;
         chk("irq clear", inmb_irq, 0);
      end
      summarize();
   end
endmodule : addon_control_nv_access_bench
`default_nettype wire
